// File: ptp_regs_pkg.sv
// Purpose: Shared constants and carriers for the time-unit register bank
// Assumes: APB with 32-bit data, byte addresses
// Notes:   Offsets are byte addresses of aligned words, except off_index_hi, the last byte of the index range
`default_nettype none
package ptp_regs_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [11:0] off_version_domain = 12'h518;
	localparam logic [11:0] off_unit_select    = 12'h520;
	localparam logic [11:0] off_trig_status    = 12'h524;
	localparam logic [11:0] off_irq_status     = 12'h5c0;
	localparam logic [11:0] off_irq_enable     = 12'h5c4;
	localparam logic [11:0] off_irq_clear      = 12'h5c8;
	localparam logic [11:0] off_msg_config     = 12'h5cc;
	localparam logic [11:0] off_index_lo       = 12'h52c;
	localparam logic [11:0] off_index_hi       = 12'h5b3;

	// ----------------------------------------
	// Field positions and resets
	// ----------------------------------------
	localparam int          version_lsb        = 8;
	localparam int          domain_lsb         = 0;
	localparam logic [3:0]  version_reset      = 4'h2;
	localparam logic [7:0]  domain_reset       = 8'h00;
	localparam int          stamp_sel_bit      = 8;
	localparam int          error_lsb          = 16;
	localparam int          done_lsb           = 0;
	localparam int          domain_check_bit   = 4;
	localparam int          num_trig           = 3;
	localparam logic [1:0]  trig_sel_reserved  = 2'h3;

	// Interrupt layout: done in 2:0, error in 5:3
	localparam int          irq_err_lsb        = 3;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic [3:0] version;
		logic [7:0] domain;
	} msg_header_s;

	typedef struct packed {
		logic       valid;
		logic       keep;
		logic       stamp;
	} filter_result_s;

	typedef struct packed {
		logic       stamp_unit;
		logic [1:0] trig_unit;
		logic       trig_valid;
	} unit_route_s;
endpackage
`default_nettype wire

// File: ptp_msg_filter.sv
// Purpose: Decides keep and capture for a received time message header
// Assumes: Header valid for one cycle, synchronous to pclk
// Notes:   Result is registered one cycle later
`default_nettype none
module ptp_msg_filter (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         hdr_valid,
	input  wire ptp_regs_pkg::msg_header_s    hdr,
	input  wire logic [3:0]                   version,
	input  wire logic [7:0]                   accepted_domain_number,
	input  wire logic                         domain_check,
	output var  ptp_regs_pkg::filter_result_s result
);
	logic version_ok;
	logic domain_ok;

	assign version_ok = (hdr.version == version);
	assign domain_ok  = !domain_check || (hdr.domain == accepted_domain_number);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result <= '0;
		end else begin
			result.valid <= hdr_valid;
			result.keep  <= hdr_valid && version_ok && domain_ok;
			result.stamp <= hdr_valid && version_ok && domain_ok;
		end
	end
endmodule
`default_nettype wire

// File: ptp_filter_index_trigger_status.sv
// Purpose: Version/domain filter, unit index and trigger status registers
// Assumes: APB slave, zero wait states except one on indexed reads
// Notes:   Trigger events arrive as one-cycle pulses per unit
`default_nettype none

// What this block does
// - Hold version field 11:8, reset 2; capture messages with matching version.
// - Drop time messages whose version differs from the stored field.
// - Hold domain field 7:0, reset 0; with checking on, capture only matches.
// - With domain checking off, ignore the message domain.
// - Indexed range accesses reach only the selected timestamp and trigger unit.
// - Bit 8 selects timestamp unit 1 when set, unit 0 when clear.
// - Bits 1:0 select trigger unit 0, 1 or 2; code 3 reserved.
// - Error flag 18:16 sets when notify on and event time already past.
// - Error flag clears on write one or on unit trigger enable cleared.
// - Done flag 2:0 sets when output made with notify on; write one clears.
// - Message config bit 4 enables domain checking; mismatches dropped.
module ptp_filter_index_trigger_status #(
	parameter int NUM_TRIG = 3
) (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [11:0]                  paddr,
	input  wire logic [31:0]                  pwdata,
	output var  logic [31:0]                  prdata,
	output var  logic                         pready,
	output var  logic                         pslverr,
	input  wire logic                         hdr_valid,
	input  wire ptp_regs_pkg::msg_header_s    hdr,
	output var  ptp_regs_pkg::filter_result_s filter_result,
	input  wire logic [NUM_TRIG-1:0]          trig_irq_on,
	input  wire logic [NUM_TRIG-1:0]          trig_enable,
	input  wire logic [NUM_TRIG-1:0]          trig_fired,
	input  wire logic [NUM_TRIG-1:0]          trig_late,
	output var  ptp_regs_pkg::unit_route_s    unit_route,
	output var  logic                         index_sel,
	output var  logic                         index_write,
	output var  logic [11:0]                  index_addr,
	output var  logic [31:0]                  index_wdata,
	input  wire logic [31:0]                  index_rdata,
	output var  logic                         irq
);
	// ----------------------------------------
	// Elaboration check
	// ----------------------------------------
	if (NUM_TRIG != ptp_regs_pkg::num_trig) begin : g_bad
		$error("NUM_TRIG must equal three");
	end
	if (ptp_regs_pkg::irq_err_lsb != NUM_TRIG) begin : g_bad_irq
		$error("Interrupt error bits must follow the done bits");
	end
	if (ptp_regs_pkg::error_lsb + NUM_TRIG > 32) begin : g_bad_width
		$error("Error flags must fit one data word");
	end

	typedef enum logic [2:0] {
		st_idle   = 3'b001,
		st_access = 3'b010,
		st_fetch  = 3'b100
	} apb_state_e;

	function automatic logic in_index(input logic [11:0] a);
		in_index = (a >= ptp_regs_pkg::off_index_lo) && (a <= ptp_regs_pkg::off_index_hi);
	endfunction

	function automatic logic is_reg(input logic [11:0] a, input logic [11:0] off);
		is_reg = ({a[11:2], 2'b00} == off);
	endfunction

	apb_state_e               state;
	apb_state_e               next_state;
	logic [3:0]               version;
	logic [7:0]               accepted_domain_number;
	logic                     stamp_unit_select;
	logic [1:0]               trig_unit_select;
	logic                     domain_check;
	logic [NUM_TRIG-1:0]      done_flag;
	logic [NUM_TRIG-1:0]      error_flag;
	logic [2*NUM_TRIG-1:0]    irq_enable;
	logic [2*NUM_TRIG-1:0]    irq_status;
	logic [NUM_TRIG-1:0]      enable_q;
	logic                     setup;
	logic                     wr;
	logic                     rd;
	logic                     mapped;
	logic                     idx;
	logic                     trig_ok;
	logic                     idx_rd;
	logic                     wr_status;
	logic                     hit_version;
	logic                     hit_select;
	logic                     hit_status;
	logic                     hit_irq_status;
	logic                     hit_irq_enable;
	logic                     hit_irq_clear;
	logic                     hit_config;
	logic [NUM_TRIG-1:0]      done_set;
	logic [NUM_TRIG-1:0]      err_set;
	logic [2*NUM_TRIG-1:0]    w1c_irq;
	logic [NUM_TRIG-1:0]      w1c_done;
	logic [NUM_TRIG-1:0]      w1c_err;
	logic [NUM_TRIG-1:0]      en_fall;
	logic [31:0]              next_rdata;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	assign setup   = psel && !penable && (state == st_idle);
	assign wr      = setup && pwrite;
	assign rd      = setup && !pwrite;
	assign idx     = in_index(paddr);
	assign idx_rd  = rd && idx;
	assign trig_ok = (trig_unit_select != ptp_regs_pkg::trig_sel_reserved);

	// ----------------------------------------
	// Register hits
	// ----------------------------------------
	assign hit_version    = is_reg(paddr, ptp_regs_pkg::off_version_domain);
	assign hit_select     = is_reg(paddr, ptp_regs_pkg::off_unit_select);
	assign hit_status     = is_reg(paddr, ptp_regs_pkg::off_trig_status);
	assign hit_irq_status = is_reg(paddr, ptp_regs_pkg::off_irq_status);
	assign hit_irq_enable = is_reg(paddr, ptp_regs_pkg::off_irq_enable);
	assign hit_irq_clear  = is_reg(paddr, ptp_regs_pkg::off_irq_clear);
	assign hit_config     = is_reg(paddr, ptp_regs_pkg::off_msg_config);
	assign mapped  = hit_version || hit_select || hit_status || hit_irq_status
		|| hit_irq_enable || hit_irq_clear || hit_config || idx;

	// Write-one-to-clear masks; a set in the same cycle still wins
	assign wr_status = wr && hit_status;
	assign w1c_done  = wr_status ? pwdata[ptp_regs_pkg::done_lsb +: NUM_TRIG] : '0;
	assign w1c_err   = wr_status ? pwdata[ptp_regs_pkg::error_lsb +: NUM_TRIG] : '0;
	assign w1c_irq   = (wr && hit_irq_clear) ? pwdata[2*NUM_TRIG-1:0] : '0;
	assign en_fall   = enable_q & ~trig_enable;
	assign done_set  = trig_fired & trig_irq_on;
	assign err_set   = trig_late & trig_irq_on;

	// ----------------------------------------
	// Transfer sequencing
	// ----------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			// Indexed reads wait one cycle for the selected unit's data
			st_idle: begin
				if (idx_rd) begin
					next_state = st_fetch;
				end else if (setup) begin
					next_state = st_access;
				end
			end
			st_fetch:  next_state = st_access;
			st_access: next_state = st_idle;
			default:   next_state = st_idle;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= st_idle;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= (setup && !idx_rd) || (state == st_fetch);
			pslverr <= setup && !mapped;
		end
	end

	// ----------------------------------------
	// Filter settings
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			version                <= ptp_regs_pkg::version_reset;
			accepted_domain_number <= ptp_regs_pkg::domain_reset;
		end else if (wr && hit_version) begin
			version                <= pwdata[ptp_regs_pkg::version_lsb +: 4];
			accepted_domain_number <= pwdata[ptp_regs_pkg::domain_lsb +: 8];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			domain_check <= 1'b0;
		end else if (wr && hit_config) begin
			domain_check <= pwdata[ptp_regs_pkg::domain_check_bit];
		end
	end

	// ----------------------------------------
	// Unit index
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stamp_unit_select <= 1'b0;
			trig_unit_select  <= 2'b00;
		end else if (wr && hit_select) begin
			stamp_unit_select <= pwdata[ptp_regs_pkg::stamp_sel_bit];
			trig_unit_select  <= pwdata[1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unit_route <= '0;
		end else begin
			unit_route.stamp_unit <= stamp_unit_select;
			unit_route.trig_unit  <= trig_unit_select;
			unit_route.trig_valid <= trig_ok;
		end
	end

	// Indexed access forwarded as a one-cycle strobe to the selected units
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			index_sel   <= 1'b0;
			index_write <= 1'b0;
			index_addr  <= 12'h000;
			index_wdata <= 32'h0000_0000;
		end else begin
			index_sel   <= setup && idx;
			index_write <= wr && idx && trig_ok;
			index_addr  <= paddr;
			index_wdata <= pwdata;
		end
	end

	// ----------------------------------------
	// Trigger status flags
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_q <= '0;
		end else begin
			enable_q <= trig_enable;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_flag <= '0;
		end else begin
			// Set wins over clear
			done_flag <= (done_flag & ~w1c_done) | done_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			error_flag <= '0;
		end else begin
			error_flag <= (error_flag & ~w1c_err & ~en_fall)
				| err_set;
		end
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_enable <= '0;
		end else if (wr && hit_irq_enable) begin
			irq_enable <= pwdata[2*NUM_TRIG-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= '0;
		end else begin
			irq_status <= (irq_status & ~w1c_irq) | {err_set, done_set};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_enable);
		end
	end

	// ----------------------------------------
	// Message filter
	// ----------------------------------------
	ptp_msg_filter u_filter (
		.pclk                   (pclk),
		.presetn                (presetn),
		.hdr_valid              (hdr_valid),
		.hdr                    (hdr),
		.version                (version),
		.accepted_domain_number (accepted_domain_number),
		.domain_check           (domain_check),
		.result                 (filter_result)
	);

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (is_reg(paddr, ptp_regs_pkg::off_version_domain)) begin
			next_rdata[ptp_regs_pkg::version_lsb +: 4] = version;
			next_rdata[ptp_regs_pkg::domain_lsb +: 8]  = accepted_domain_number;
		end else if (is_reg(paddr, ptp_regs_pkg::off_unit_select)) begin
			next_rdata[ptp_regs_pkg::stamp_sel_bit] = stamp_unit_select;
			next_rdata[1:0]                         = trig_unit_select;
		end else if (is_reg(paddr, ptp_regs_pkg::off_trig_status)) begin
			next_rdata[ptp_regs_pkg::error_lsb +: NUM_TRIG] = error_flag;
			next_rdata[ptp_regs_pkg::done_lsb +: NUM_TRIG]  = done_flag;
		end else if (is_reg(paddr, ptp_regs_pkg::off_irq_status)) begin
			next_rdata[2*NUM_TRIG-1:0] = irq_status;
		end else if (is_reg(paddr, ptp_regs_pkg::off_irq_enable)) begin
			next_rdata[2*NUM_TRIG-1:0] = irq_enable;
		end else if (is_reg(paddr, ptp_regs_pkg::off_msg_config)) begin
			next_rdata[ptp_regs_pkg::domain_check_bit] = domain_check;
		end
	end

	// Indexed reads load unit data at the end of the wait cycle, on the same edge that raises pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd && !idx) begin
			prdata <= next_rdata;
		end else if (state == st_fetch) begin
			// Reserved trigger index reads as zero
			prdata <= trig_ok ? index_rdata : 32'h0000_0000;
		end
	end
endmodule
`default_nettype wire

// File: ptp_filter_index_trigger_status_props.sv
// Purpose: Port-level checks of the time-unit register bank
// Assumes: APB, one wait state on indexed reads, writes land at the setup edge
// Notes:   Shadow fields follow the host writes that the checks need
`default_nettype none
module ptp_filter_index_trigger_status_props (
	input wire logic                         pclk,
	input wire logic                         presetn,
	input wire logic                         psel,
	input wire logic                         penable,
	input wire logic                         pwrite,
	input wire logic [11:0]                  paddr,
	input wire logic [31:0]                  pwdata,
	input wire logic                         pready,
	input wire logic                         pslverr,
	input wire logic                         hdr_valid,
	input wire ptp_regs_pkg::msg_header_s    hdr,
	input wire ptp_regs_pkg::filter_result_s filter_result,
	input wire ptp_regs_pkg::unit_route_s    unit_route,
	input wire logic                         index_sel,
	input wire logic                         index_write
);
	// ----------------------------------------
	// Shadow fields
	// ----------------------------------------
	logic [3:0] ver;
	logic [7:0] dom;
	logic       chk;
	logic [1:0] tsel;
	logic       setup;
	logic       wr;
	logic       in_idx;
	logic       mapped;
	assign setup = psel && !penable;
	assign wr = setup && pwrite;
	assign in_idx = paddr >= 12'h52c && paddr <= 12'h5b3;
	assign mapped = in_idx || paddr inside {12'h518, 12'h520, 12'h524, 12'h5c0, 12'h5c4,
		12'h5c8, 12'h5cc};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{ver, dom} <= 12'h200;
			chk <= 1'b0;
			tsel <= 2'h0;
		end else if (wr) begin
			if (paddr == 12'h518) {ver, dom} <= pwdata[11:0];
			if (paddr == 12'h5cc) chk <= pwdata[4];
			if (paddr == 12'h520) tsel <= pwdata[1:0];
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	rdy_setup_a: assert property (setup && !(in_idx && !pwrite) |=> pready && penable)
		else $error("ready missing after setup");
	idx_wait_a: assert property (setup && in_idx && !pwrite |=> !pready ##1 pready)
		else $error("indexed read wait state wrong");
	rdy_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	unmapped_err_a: assert property (setup && !mapped |=> pslverr && pready)
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (setup && mapped |=> !pslverr)
		else $error("mapped access refused");
	idx_sel_a: assert property (setup |=> index_sel == $past(in_idx))
		else $error("indexed select wrong");
	resv_nowr_a: assert property (wr && in_idx && tsel == 2'h3 |=> !index_write)
		else $error("write issued on reserved index");
	idx_wr_a: assert property (wr && in_idx && tsel != 2'h3 |=> index_write)
		else $error("indexed write not issued");
	route_copy_a: assert property (wr && paddr == 12'h520 |=> ##1
		unit_route.trig_unit == $past(pwdata[1:0], 2) && unit_route.stamp_unit == $past(pwdata[8], 2))
		else $error("unit route does not follow index");
	ver_drop_a: assert property (hdr_valid && hdr.version != ver |=>
		!filter_result.keep && !filter_result.stamp)
		else $error("wrong version kept");
	dom_drop_a: assert property (hdr_valid && chk && hdr.domain != dom |=>
		!filter_result.keep && !filter_result.stamp)
		else $error("wrong domain kept");
	match_keep_a: assert property (hdr_valid && hdr.version == ver && (!chk || hdr.domain == dom)
		|=> filter_result.valid && filter_result.keep && filter_result.stamp)
		else $error("matching message not kept");
endmodule

bind ptp_filter_index_trigger_status ptp_filter_index_trigger_status_props u_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .hdr_valid(hdr_valid),
	.hdr(hdr), .filter_result(filter_result), .unit_route(unit_route), .index_sel(index_sel),
	.index_write(index_write));
`default_nettype wire

// File: ptp_filter_index_trigger_status_test.sv
// Purpose: Self-checking bench of the time-unit register bank
// Assumes: APB slave, one wait state on indexed reads, one clock
// Notes:   Expected results wait in queues for the output monitor
`default_nettype none
module ptp_filter_index_trigger_status_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic                         pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0]                  paddr;
	logic [31:0]                  pwdata, prdata, index_rdata, index_wdata;
	logic [11:0]                  index_addr;
	logic                         index_sel, index_write;
	ptp_regs_pkg::unit_route_s    unit_route;
	logic [44:0]                  idx_q[$];
	logic                         hdr_valid, irq;
	ptp_regs_pkg::msg_header_s    hdr;
	ptp_regs_pkg::filter_result_s filter_result;
	logic [2:0]                   trig_irq_on, trig_enable, trig_fired, trig_late;
	int                           error_cnt, tests_run, cycles;
	logic [33:0]                  rd_q[$];
	logic [1:0]                   flt_q[$];

	ptp_filter_index_trigger_status #(.NUM_TRIG(3)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.hdr_valid(hdr_valid), .hdr(hdr), .filter_result(filter_result),
		.trig_irq_on(trig_irq_on), .trig_enable(trig_enable), .trig_fired(trig_fired),
		.trig_late(trig_late), .unit_route(unit_route), .index_sel(index_sel),
		.index_write(index_write), .index_addr(index_addr), .index_wdata(index_wdata),
		.index_rdata(index_rdata), .irq(irq));

	always #5 pclk = ~pclk;

	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] e, input logic chk_d, input logic er);
		rd_q.push_back({chk_d, er, e});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, e, 1'b1, 1'b0);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 1'b0, 1'b0);
	endtask

	// ----------------------------------------
	// Output monitor and hang guard
	// ----------------------------------------
	always @(posedge pclk) begin
		logic [33:0] n;
		logic [1:0]  f;
		logic [44:0] x;
		if (psel && penable && pready === 1'b1) begin
			n = rd_q.pop_front();
			check("pslverr", 32'(pslverr), 32'(n[32]));
			if (n[33]) check("prdata", prdata, n[31:0]);
		end
		if (filter_result.valid === 1'b1) begin
			f = flt_q.pop_front();
			check("filter", 32'({filter_result.keep, filter_result.stamp}), 32'(f));
		end
		if (index_sel === 1'b1) begin
			x = idx_q.pop_front();
			check("index_write", 32'(index_write), 32'(x[44]));
			check("index_addr", 32'(index_addr), 32'(x[43:32]));
			check("index_wdata", index_wdata, x[31:0]);
		end
	end

	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			error_cnt++;
			summarize();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] d;
		logic [3:0]  v;
		logic [7:0]  dm;
		logic        c;
		logic        k;
		logic [11:0] ia;
		logic [31:0] iw;
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata, hdr_valid, hdr} = '0;
		{trig_irq_on, trig_enable, trig_fired, trig_late, index_rdata} = '0;
		{error_cnt, tests_run, cycles} = '0;
		void'($urandom(94));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		trig_enable <= 3'h7;
		index_rdata <= $urandom();
		@(posedge pclk);
		rd(12'h518, 32'h200);
		rd(12'h520, 32'h0);
		rd(12'h524, 32'h0);
		rd(12'h5cc, 32'h0);
		d = $urandom();
		wr(12'h518, d);
		rd(12'h518, d & 32'hfff);
		for (int i = 0; i < 4; i++) begin
			d = ($urandom() & ~32'h3) | 32'(i);
			wr(12'h520, d);
			check("route", 32'(unit_route), {28'h0, d[8], d[1:0], 1'(i != 3)});
			rd(12'h520, d & 32'h103);
			ia = 12'h52c + 12'(4 * i);
			iw = $urandom();
			idx_q.push_back({1'(i != 3), ia, iw});
			wr(ia, iw);
			idx_q.push_back({1'b0, ia, 32'h0});
			rd(ia, (i == 3) ? 32'h0 : index_rdata);
		end
		apb(1'b0, 12'h51c, 32'h0, 32'h0, 1'b0, 1'b1);
		apb(1'b1, 12'h5d0, $urandom(), 32'h0, 1'b0, 1'b1);
		for (int i = 0; i < 16; i++) begin
			c = i[0];
			v = 4'($urandom());
			dm = 8'($urandom());
			wr(12'h5cc, 32'({c, 4'h0}));
			wr(12'h518, {20'h0, v, dm});
			hdr.version <= $urandom() % 2 ? v : v + 4'h1;
			hdr.domain <= $urandom() % 2 ? dm : dm ^ 8'h01;
			hdr_valid <= 1'b1;
			@(posedge pclk);
			k = hdr.version == v && (!c || hdr.domain == dm);
			flt_q.push_back({k, k});
			hdr_valid <= 1'b0;
			@(posedge pclk);
		end
		for (int u = 0; u < 3; u++) begin
			trig_irq_on <= 3'(1 << u);
			trig_fired <= 3'h7;
			trig_late <= 3'h7;
			@(posedge pclk);
			{trig_fired, trig_late} <= '0;
			@(posedge pclk);
			rd(12'h524, (32'h1 << u) | (32'h1 << (16 + u)));
			rd(12'h5c0, (32'h1 << u) | (32'h1 << (3 + u)));
			check("irq", 32'(irq), 32'h0);
			wr(12'h5c4, 32'h3f);
			check("irq", 32'(irq), 32'h1);
			wr(12'h5c8, 32'h3f);
			@(posedge pclk);
			check("irq", 32'(irq), 32'h0);
			rd(12'h5c0, 32'h0);
			wr(12'h524, 32'h1 << u);
			rd(12'h524, 32'h1 << (16 + u));
			trig_enable <= 3'h7 ^ 3'(1 << u);
			repeat (2) @(posedge pclk);
			trig_enable <= 3'h7;
			rd(12'h524, 32'h0);
			trig_late <= 3'(1 << u);
			@(posedge pclk);
			trig_late <= 3'h0;
			@(posedge pclk);
			rd(12'h524, 32'h1 << (16 + u));
			wr(12'h524, 32'h1 << (16 + u));
			rd(12'h524, 32'h0);
			wr(12'h5c8, 32'h3f);
			wr(12'h5c4, 32'h0);
		end
		repeat (3) @(posedge pclk);
		summarize();
	end
endmodule
`default_nettype wire
